/* verilog/t1dlm_pkg.sv */
// Register map, field layout, reset values and timing constants of the data link message map
package t1dlm_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [9:0] IDX_REPORT_CTL   = 10'h07f;
  localparam logic [9:0] IDX_TX_CODE      = 10'h080;
  localparam logic [9:0] IDX_RX_CTL       = 10'h081;
  localparam logic [9:0] IDX_RX_FLAG      = 10'h082;
  localparam logic [9:0] IDX_RX_CODE      = 10'h083;
  localparam logic [9:0] IDX_TX_ENABLE    = 10'h084;
  localparam logic [9:0] IDX_TX2_ASSIGN   = 10'h086;
  localparam logic [9:0] IDX_TX3_ASSIGN   = 10'h087;
  localparam logic [9:0] IDX_TX2_MASK     = 10'h089;
  localparam logic [9:0] IDX_TX3_MASK     = 10'h08a;
  localparam logic [9:0] IDX_RX_ENABLE    = 10'h08b;
  localparam logic [9:0] IDX_RX2_ASSIGN   = 10'h08d;
  localparam logic [9:0] IDX_RX3_ASSIGN   = 10'h08e;
  localparam logic [9:0] IDX_FORMAT       = 10'h0a8;
  localparam logic [9:0] IDX_IRQ_MASK     = 10'h0a9;
  localparam int         ADDR_W           = 12;

  // Field positions
  localparam int RPT_AUTO_BIT   = 0;
  localparam int RX_RX_CODE_IRQ_ENABLE_BIT    = 4;
  localparam int RX_AVC_BIT     = 5;
  localparam int ASG_ODD_BIT    = 5;
  localparam int ASG_EVEN_BIT   = 6;
  localparam int FMT_ESF_BIT    = 0;
  localparam int FMT_DM_BIT     = 1;

  // Reset values
  localparam logic [5:0] CODE_IDLE      = 6'h3f;
  localparam logic [1:0] FORMAT_RESET   = 2'h1;
  localparam logic       IRQ_MASK_RESET = 1'b1;

  // Channel and message constants
  localparam logic [4:0] LAST_CHANNEL   = 5'h17;
  localparam logic [3:0] BOM_LAST_POS   = 4'hf;
  localparam logic [3:0] BOM_CODE_POS   = 4'h9;
  localparam logic [7:0] BOM_PREAMBLE   = 8'hff;
  localparam logic [3:0] WIN_STRICT     = 4'ha;
  localparam logic [3:0] HIT_STRICT     = 4'h8;
  localparam logic [3:0] WIN_FAST       = 4'h5;
  localparam logic [3:0] HIT_FAST       = 4'h4;

  // Bus answers
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // Timing: report period and clock rate
  localparam longint REPORT_PERIOD_MS = 1000;
  localparam longint CLK_PERIOD_NS    = 10;
  localparam int     REPORT_CYCLES    = int'((REPORT_PERIOD_MS * 1000000) / CLK_PERIOD_NS);

  // Transmit serializer states
  typedef enum logic [1:0] {
    T1DLM_TX_IDLE = 2'b01,
    T1DLM_TX_SEND = 2'b10
  } t1dlm_tx_state_t;
endpackage

/* verilog/t1dlm_top.sv */
// Data link message map: bit-oriented messages, report timer and HDLC channel mapping
// Notes on behaviour
// - Send performance report every second in EXTENDED_SUPERFRAME_FORMAT
// - No report when disabled or not EXTENDED_SUPERFRAME_FORMAT
// - Non-all-ones code sent continuously in EXTENDED_SUPERFRAME_FORMAT
// - Pattern: eight ones, zero, code 0..5, zero
// - Select 0: 8 of 10, new code
// - Select 1: 4 of 5, new code
// - Declared code loads field, bit5 LSB
// - Update flag set on load, write-one clears
// - Flag interrupts only while enable set
// - Transmitter enables; one needs EXTENDED_SUPERFRAME_FORMAT or DM
// - Receiver enables; one needs EXTENDED_SUPERFRAME_FORMAT or DM
// - Transmit insertion by even/odd frame select
// - Transmit channel 0..23, ignored if unselected
// - Mask bit 7 is channel MSB
// - Mask ignored with both selects clear
// - Receive extraction by even/odd frame select
// - Receive channel 0..23, ignored if unselected
// - Report carries five programmed bits
module t1dlm_top
  import t1dlm_pkg::*;
#(
  parameter int REPORT_CYCLES_P = t1dlm_pkg::REPORT_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // AXI4-Lite slave
  input  wire logic [t1dlm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [t1dlm_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Data link bit slots from the framer
  input  wire logic                   tx_dl_strobe,
  output logic                        tx_dl_bit,
  output logic                        tx_dl_bom_active,
  input  wire logic                   rx_dl_strobe,
  input  wire logic                   rx_dl_bit,
  // Report hand-off to transmitter one
  output logic                        report_valid,
  output logic [4:0]                  report_bits,
  input  wire logic                   report_ready,
  // Timeslot position from the framer
  input  wire logic                   slot_strobe,
  input  wire logic                   frame_odd,
  input  wire logic [4:0]             slot_channel,
  input  wire logic [2:0]             slot_bit,
  output logic                        tx2_insert,
  output logic                        tx3_insert,
  output logic                        rx2_extract,
  output logic                        rx3_extract,
  output logic [2:0]                  tx_link_active,
  output logic [2:0]                  rx_link_active,
  output logic                        irq
);
  import t1dlm_pkg::*;

  // Whole state of the block in one record
  typedef struct packed {
    logic [5:0]      tx_code;      // Transmit code field
    logic [7:0]      rx_ctl;       // Validation select and irq enable
    logic            flag;         // Received-code update flag
    logic            irq_mask;     // Extra gate on the flag
    logic [5:0]      rx_code;      // Received code field
    logic [2:0]      tx_en;        // Transmitter enables
    logic [6:0]      tx2_asg;      // Even/odd/channel, transmitter two
    logic [6:0]      tx3_asg;      // Even/odd/channel, transmitter three
    logic [7:0]      tx2_mask;     // Bit mask, transmitter two
    logic [7:0]      tx3_mask;     // Bit mask, transmitter three
    logic [2:0]      rx_en;        // Receiver enables
    logic [6:0]      rx2_asg;      // Even/odd/channel, receiver two
    logic [6:0]      rx3_asg;      // Even/odd/channel, receiver three
    logic [5:0]      rpt_ctl;      // Report bits and auto enable
    logic [1:0]      fmt;          // Line format: EXTENDED_SUPERFRAME_FORMAT, DM
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
    t1dlm_tx_state_t tx_state;     // Serializer state
    logic [3:0]      tx_pos;       // Bit position in the pattern
    logic [5:0]      tx_cur;       // Code latched for this pattern
    logic            tx_bit;
    logic            tx_active;
    logic [15:0]     rx_sr;        // Last sixteen received link bits
    logic [5:0]      cand;         // Candidate message
    logic [3:0]      win;          // Messages seen in this window
    logic [3:0]      hits;         // Messages equal to the candidate
    logic [31:0]     sec_cnt;      // One-second divider
    logic            rpt_valid;
    logic [4:0]      rpt_bits;
    logic            tx2_ins;
    logic            tx3_ins;
    logic            rx2_ext;
    logic            rx3_ext;
    logic [2:0]      tx_act;
    logic [2:0]      rx_act;
    logic            irq;
  } t1dlm_state_t;

  t1dlm_state_t st_reg;
  t1dlm_state_t st_next;

  // Reset image of the state
  localparam t1dlm_state_t ST_RESET = '{
    tx_code: CODE_IDLE, rx_code: CODE_IDLE, fmt: FORMAT_RESET, irq_mask: IRQ_MASK_RESET,
    tx_state: T1DLM_TX_IDLE, bresp: RESP_OKAY, rresp: RESP_OKAY, default: '0};

  // Pattern bit at a given position
  function automatic logic bom_bit(input logic [5:0] code, input logic [3:0] pos);
    logic [3:0] k;
    k = pos - BOM_CODE_POS;
    if (pos < 4'h8) begin
      bom_bit = 1'b1;
    end else if (pos == 4'h8 || pos == BOM_LAST_POS) begin
      bom_bit = 1'b0;
    end else begin
      bom_bit = code[k[2:0]];
    end
  endfunction

  // Slot decode for a mapped channel; shared by all four links
  function automatic logic slot_hit(input logic [6:0] asg, input logic [7:0] mask, input logic en,
                                    input logic odd, input logic [4:0] ch, input logic [2:0] bitn);
    logic sel;
    sel = odd ? asg[ASG_ODD_BIT] : asg[ASG_EVEN_BIT];
    // Both selects clear gives sel=0, so channel and mask are ignored
    slot_hit = en & sel & (asg[4:0] == ch) & (asg[4:0] <= LAST_CHANNEL) & mask[~bitn];
  endfunction

  // Next-state logic
  always_comb begin
    logic       extended_superframe_format;
    logic       dm;
    logic       wr;
    logic       rd;
    logic [9:0] widx;
    logic [9:0] ridx;
    logic [7:0] wd;
    logic       hit_ok;
    logic [7:0] rv;
    logic [15:0] sr;
    logic [5:0] msg;
    logic [3:0] thr;
    logic [3:0] wlen;
    logic       decl;
    logic       clr;
    extended_superframe_format    = 1'b0;
    dm     = 1'b0;
    wr     = 1'b0;
    rd     = 1'b0;
    widx   = '0;
    ridx   = '0;
    wd     = '0;
    hit_ok = 1'b0;
    rv     = '0;
    sr     = '0;
    msg    = '0;
    thr    = '0;
    wlen   = '0;
    decl   = 1'b0;
    clr    = 1'b0;
    st_next = st_reg;
    extended_superframe_format = st_reg.fmt[FMT_ESF_BIT];
    dm  = st_reg.fmt[FMT_DM_BIT];

    // Write channel: take address and data together, one write at a time
    st_next.awready = 1'b0;
    st_next.wready  = 1'b0;
    if (s_axi_awvalid && s_axi_wvalid && !st_reg.awready && !st_reg.bvalid) begin
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end
    wr   = st_reg.awready & s_axi_awvalid & s_axi_wvalid;
    widx = s_axi_awaddr[ADDR_W-1:2];
    wd   = s_axi_wdata[7:0];
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr) begin
      st_next.bvalid = 1'b1;
      hit_ok = 1'b1;
      // Only the low byte lane carries register data
      if (s_axi_wstrb[0]) begin
        case (widx)
          IDX_REPORT_CTL: st_next.rpt_ctl = wd[5:0];
          IDX_TX_CODE:    st_next.tx_code = wd[5:0];
          IDX_RX_CTL:     st_next.rx_ctl = {2'h0, wd[RX_AVC_BIT], wd[RX_RX_CODE_IRQ_ENABLE_BIT], 4'h0};
          IDX_RX_FLAG:    clr = wd[0];
          IDX_RX_CODE:    ;                 // Read-only, write ignored
          IDX_TX_ENABLE:  st_next.tx_en = wd[2:0];
          IDX_TX2_ASSIGN: st_next.tx2_asg = wd[6:0];
          IDX_TX3_ASSIGN: st_next.tx3_asg = wd[6:0];
          IDX_TX2_MASK:   st_next.tx2_mask = wd;
          IDX_TX3_MASK:   st_next.tx3_mask = wd;
          IDX_RX_ENABLE:  st_next.rx_en = wd[2:0];
          IDX_RX2_ASSIGN: st_next.rx2_asg = wd[6:0];
          IDX_RX3_ASSIGN: st_next.rx3_asg = wd[6:0];
          IDX_FORMAT:     st_next.fmt = wd[1:0];
          IDX_IRQ_MASK:   st_next.irq_mask = wd[0];
          default:        hit_ok = 1'b0;
        endcase
      end else begin
        hit_ok = (widx == IDX_REPORT_CTL) || (widx >= IDX_TX_CODE && widx <= IDX_RX3_ASSIGN) ||
                 (widx == IDX_FORMAT) || (widx == IDX_IRQ_MASK);
      end
      st_next.bresp = hit_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Read channel: one read at a time, answer two cycles after valid
    st_next.arready = 1'b0;
    if (s_axi_arvalid && !st_reg.arready && !st_reg.rvalid) begin
      st_next.arready = 1'b1;
    end
    rd   = st_reg.arready & s_axi_arvalid;
    ridx = s_axi_araddr[ADDR_W-1:2];
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (rd) begin
      hit_ok = 1'b1;
      case (ridx)
        IDX_REPORT_CTL: rv = {2'h0, st_reg.rpt_ctl};
        IDX_TX_CODE:    rv = {2'h0, st_reg.tx_code};
        IDX_RX_CTL:     rv = st_reg.rx_ctl;
        IDX_RX_FLAG:    rv = {7'h0, st_reg.flag};
        IDX_RX_CODE:    rv = {2'h0, st_reg.rx_code};
        IDX_TX_ENABLE:  rv = {5'h0, st_reg.tx_en};
        IDX_TX2_ASSIGN: rv = {1'b0, st_reg.tx2_asg};
        IDX_TX3_ASSIGN: rv = {1'b0, st_reg.tx3_asg};
        IDX_TX2_MASK:   rv = st_reg.tx2_mask;
        IDX_TX3_MASK:   rv = st_reg.tx3_mask;
        IDX_RX_ENABLE:  rv = {5'h0, st_reg.rx_en};
        IDX_RX2_ASSIGN: rv = {1'b0, st_reg.rx2_asg};
        IDX_RX3_ASSIGN: rv = {1'b0, st_reg.rx3_asg};
        IDX_FORMAT:     rv = {6'h0, st_reg.fmt};
        IDX_IRQ_MASK:   rv = {7'h0, st_reg.irq_mask};
        default:        hit_ok = 1'b0;   // Unmapped: zero data, slave error
      endcase
      st_next.rvalid = 1'b1;
      st_next.rdata  = {24'h0, rv};
      st_next.rresp  = hit_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Transmit pattern: code latched per pattern so a write never splits one
    if (tx_dl_strobe) begin
      case (st_reg.tx_state)
        T1DLM_TX_IDLE: begin
          if (extended_superframe_format && st_reg.tx_code != CODE_IDLE) begin
            st_next.tx_state  = T1DLM_TX_SEND;
            st_next.tx_cur    = st_reg.tx_code;
            st_next.tx_pos    = 4'h1;
            st_next.tx_bit    = bom_bit(st_reg.tx_code, 4'h0);
            st_next.tx_active = 1'b1;
          end else begin
            st_next.tx_bit    = 1'b1;
            st_next.tx_active = 1'b0;
          end
        end
        T1DLM_TX_SEND: begin
          st_next.tx_bit = bom_bit(st_reg.tx_cur, st_reg.tx_pos);
          st_next.tx_pos = st_reg.tx_pos + 4'h1;
          if (st_reg.tx_pos == BOM_LAST_POS) begin
            // Repeat while the code stays programmed, else fall idle after this pattern
            st_next.tx_pos = '0;
            if (!(extended_superframe_format && st_reg.tx_code != CODE_IDLE)) begin
              st_next.tx_state = T1DLM_TX_IDLE;
            end else begin
              st_next.tx_cur = st_reg.tx_code;
            end
          end
        end
        default: begin
          st_next.tx_state = T1DLM_TX_IDLE;
        end
      endcase
    end

    // Receive validation; windows also restart when EXTENDED_SUPERFRAME_FORMAT is cleared
    thr  = st_reg.rx_ctl[RX_AVC_BIT] ? HIT_FAST : HIT_STRICT;
    wlen = st_reg.rx_ctl[RX_AVC_BIT] ? WIN_FAST : WIN_STRICT;
    if (!extended_superframe_format) begin
      st_next.rx_sr = '0;
      st_next.win   = '0;
    end else if (rx_dl_strobe) begin
      sr = {st_reg.rx_sr[14:0], rx_dl_bit};
      st_next.rx_sr = sr;
      if (sr[15:8] == BOM_PREAMBLE && !sr[7] && !sr[0]) begin
        // First code bit received is the message MSB, so it lands in field bit 0
        msg = {sr[1], sr[2], sr[3], sr[4], sr[5], sr[6]};
        st_next.rx_sr = '0;                       // Cleared so patterns never overlap
        if (st_reg.win == 4'h0) begin
          st_next.cand = msg;
          st_next.win  = 4'h1;
          st_next.hits = 4'h1;
        end else begin
          st_next.win  = st_reg.win + 4'h1;
          st_next.hits = st_reg.hits + ((msg == st_reg.cand) ? 4'h1 : 4'h0);
        end
        if (st_next.hits == thr) begin
          decl = (st_next.cand != st_reg.rx_code);
          st_next.win = '0;
        end else if (st_next.win == wlen) begin
          st_next.win = '0;                       // Window failed; next message starts afresh
        end
      end
    end
    if (decl) begin
      st_next.rx_code = st_next.cand;
    end
    // Set wins over a write-one clear in the same cycle
    st_next.flag = (st_reg.flag & ~clr) | decl;
    st_next.irq  = st_next.flag & st_next.rx_ctl[RX_RX_CODE_IRQ_ENABLE_BIT] & st_next.irq_mask;

    // One-second report timer; stays quiet unless enabled in EXTENDED_SUPERFRAME_FORMAT
    if (extended_superframe_format && st_reg.rpt_ctl[RPT_AUTO_BIT]) begin
      if (st_reg.sec_cnt >= 32'(REPORT_CYCLES_P - 1)) begin
        st_next.sec_cnt   = '0;
        st_next.rpt_valid = 1'b1;
        st_next.rpt_bits  = st_reg.rpt_ctl[5:1];
      end else begin
        st_next.sec_cnt = st_reg.sec_cnt + 32'h1;
      end
    end else begin
      st_next.sec_cnt   = '0;
      st_next.rpt_valid = 1'b0;
    end
    if (st_reg.rpt_valid && report_ready) begin
      st_next.rpt_valid = 1'b0;
    end

    // Link enables; link one only in EXTENDED_SUPERFRAME_FORMAT or DM
    st_next.tx_act = {st_reg.tx_en[2:1], st_reg.tx_en[0] & (extended_superframe_format | dm)};
    st_next.rx_act = {st_reg.rx_en[2:1], st_reg.rx_en[0] & (extended_superframe_format | dm)};

    // Timeslot mapping, one cycle after the slot strobe
    st_next.tx2_ins = slot_strobe & slot_hit(st_reg.tx2_asg, st_reg.tx2_mask, st_reg.tx_en[1],
                                             frame_odd, slot_channel, slot_bit);
    st_next.tx3_ins = slot_strobe & slot_hit(st_reg.tx3_asg, st_reg.tx3_mask, st_reg.tx_en[2],
                                             frame_odd, slot_channel, slot_bit);
    st_next.rx2_ext = slot_strobe & slot_hit(st_reg.rx2_asg, 8'hff, st_reg.rx_en[1],
                                             frame_odd, slot_channel, slot_bit);
    st_next.rx3_ext = slot_strobe & slot_hit(st_reg.rx3_asg, 8'hff, st_reg.rx_en[2],
                                             frame_odd, slot_channel, slot_bit);
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready    = st_reg.awready;
  assign s_axi_wready     = st_reg.wready;
  assign s_axi_bvalid     = st_reg.bvalid;
  assign s_axi_bresp      = st_reg.bresp;
  assign s_axi_arready    = st_reg.arready;
  assign s_axi_rvalid     = st_reg.rvalid;
  assign s_axi_rresp      = st_reg.rresp;
  assign s_axi_rdata      = st_reg.rdata;
  assign tx_dl_bit        = st_reg.tx_bit;
  assign tx_dl_bom_active = st_reg.tx_active;
  assign report_valid     = st_reg.rpt_valid;
  assign report_bits      = st_reg.rpt_bits;
  assign tx2_insert       = st_reg.tx2_ins;
  assign tx3_insert       = st_reg.tx3_ins;
  assign rx2_extract      = st_reg.rx2_ext;
  assign rx3_extract      = st_reg.rx3_ext;
  assign tx_link_active   = st_reg.tx_act;
  assign rx_link_active   = st_reg.rx_act;
  assign irq              = st_reg.irq;
endmodule

/* verification/t1dlm_checker.sv */
// Port-level assertions for the data link message map
module t1dlm_checker (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       tx_dl_strobe,
  input wire logic       tx_dl_bit,
  input wire logic       tx_dl_bom_active,
  input wire logic       report_valid,
  input wire logic       report_ready,
  input wire logic [4:0] report_bits,
  input wire logic       slot_strobe,
  input wire logic [4:0] slot_channel,
  input wire logic       tx2_insert,
  input wire logic       tx3_insert,
  input wire logic       rx2_extract,
  input wire logic [2:0] tx_link_active
);
  import t1dlm_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A pattern always opens with a one
  property p_bom_start; $rose(tx_dl_bom_active) |-> tx_dl_bit; endproperty
  a_bom_start: assert property (p_bom_start) else $error("pattern opened low");
  // Line bit moves only after a transmit link bit strobe
  property p_bit_hold; !$past(tx_dl_strobe) |-> $stable(tx_dl_bit); endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("line bit moved without strobe");
  // Idle slots carry ones
  property p_idle; !tx_dl_bom_active && $past(tx_dl_strobe) |-> tx_dl_bit; endproperty
  a_idle: assert property (p_idle) else $error("idle slot not one");
  // Report and its bits stand until taken
  property p_rpt_hold; report_valid && !report_ready |=> report_valid && $stable(report_bits); endproperty
  a_rpt_hold: assert property (p_rpt_hold) else $error("report dropped early");
  // Insertion needs an enabled transmitter, and on link two also a strobe
  property p_tx2_cause; tx2_insert |-> $past(slot_strobe) && $past(tx_link_active[1]); endproperty
  a_tx2_cause: assert property (p_tx2_cause) else $error("stray insert two");
  property p_tx2_chan; tx2_insert |-> $past(slot_channel) <= LAST_CHANNEL; endproperty
  a_tx2_chan: assert property (p_tx2_chan) else $error("insert on bad channel");
  property p_rx2_chan; rx2_extract |-> $past(slot_strobe) && $past(slot_channel) <= LAST_CHANNEL; endproperty
  a_rx2_chan: assert property (p_rx2_chan) else $error("extract on bad channel");
  property p_tx3_cause; tx3_insert |-> $past(tx_link_active[2]); endproperty
  a_tx3_cause: assert property (p_tx3_cause) else $error("insert three while off");
endmodule

/* verification/t1dlm_far_end.sv */
// Remote terminal model: sends messages on the receive link, takes reports slowly
module t1dlm_far_end (
  input  wire logic clk_sys,
  input  wire logic report_valid,
  output logic      report_ready,
  output logic      rx_dl_strobe,
  output logic      rx_dl_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lag;  // Delays acceptance so the device must hold its report
  initial begin
    report_ready = 1'b0;
    rx_dl_strobe = 1'b0;
    rx_dl_bit    = 1'b0;
    lag          = 1'b0;
  end
  // Slow acceptor: ready one cycle, two cycles after valid
  always @(posedge clk_sys) begin
    lag          <= report_valid;
    report_ready <= lag & report_valid & ~report_ready;
  end
  // Bit k of the message pattern
  function automatic logic bit_oriented_message(input logic [5:0] c, input int k);
    return (k < 8) ? 1'b1 : (k == 8 || k == 15) ? 1'b0 : c[k-9];
  endfunction
  // Sends n whole patterns; line inverts between slots, no pull on it
  task automatic send(input logic [5:0] c, input int n);
    repeat (n) for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      rx_dl_strobe <= 1'b1;
      rx_dl_bit    <= bit_oriented_message(c, k);
      @(posedge clk_sys);
      rx_dl_strobe <= 1'b0;
      rx_dl_bit    <= ~bit_oriented_message(c, k);
    end
  endtask
endmodule

/* verification/test_t1_data_link_message_map.sv */
// Testbench: registers, transmit pattern, received codes, reports, timeslot map
module test_t1_data_link_message_map;
  timeunit 1ns;
  timeprecision 1ps;
  import t1dlm_pkg::*;
  logic              clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, td, sd;
  logic              tx_dl_strobe, tx_dl_bit, tx_dl_bom_active, rx_dl_strobe, rx_dl_bit, report_valid;
  logic              report_ready, slot_strobe, frame_odd, tx2_insert, tx3_insert, rx2_extract, rx3_extract;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [4:0]        report_bits, slot_channel, ch;
  logic [2:0]        slot_bit, tx_link_active, rx_link_active;
  logic [5:0]        c, m;
  logic [31:0]       rq[$], tq[$], pq[$], sq[$];  // Expected reads, line bits, reports, slot flags
  int                n_fail, num_checks, cyc;
  // Short report period keeps the run brief
  t1dlm_top #(.REPORT_CYCLES_P(50)) i_dut (.*);
  t1dlm_far_end i_far (.clk_sys(clk_sys), .report_valid(report_valid), .report_ready(report_ready),
                       .rx_dl_strobe(rx_dl_strobe), .rx_dl_bit(rx_dl_bit));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Bus write: address and data together, held until taken
  task wr(input logic [9:0] i, input logic [7:0] d);
    @(posedge clk_sys);
    s_axi_awaddr  <= {i, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
    s_axi_bready  <= 1'b0;
  endtask
  // Bus read; the monitor compares the data
  task rd(input logic [9:0] i, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clk_sys);
    s_axi_araddr  <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    chk({30'h0, s_axi_rresp}, {30'h0, (i == 10'h3ff) ? RESP_SLVERR : RESP_OKAY});
    s_axi_rready  <= 1'b0;
  endtask
  task pulse_tx(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      tx_dl_strobe <= 1'b1;
      @(posedge clk_sys);
      tx_dl_strobe <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask
  task slot(input logic odd, input logic [4:0] n, input logic [2:0] b, input logic [3:0] e);
    sq.push_back({28'h0, e});
    @(posedge clk_sys);
    slot_strobe  <= 1'b1;
    frame_odd    <= odd;
    slot_channel <= n;
    slot_bit     <= b;
    @(posedge clk_sys);
    slot_strobe  <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Monitor: takes the oldest note when a result shows; also cuts a hang short
  always @(posedge clk_sys) begin
    td  <= tx_dl_strobe;
    sd  <= slot_strobe;
    cyc <= cyc + 1;
    if (s_axi_rvalid && s_axi_rready) chk(s_axi_rdata, rq.pop_front());
    if (td) chk({31'h0, tx_dl_bit}, tq.pop_front());
    if (sd) chk({28'h0, tx2_insert, tx3_insert, rx2_extract, rx3_extract}, sq.pop_front());
    if (report_valid && report_ready && pq.size() > 0) chk({27'h0, report_bits}, pq.pop_front());
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {tx_dl_strobe, slot_strobe, frame_odd, td, sd} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, slot_channel, slot_bit} = '0;
    s_axi_wstrb = 4'hf;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    c = 6'($urandom(32'ha074));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(IDX_TX_CODE, 32'h3f);
    rd(IDX_RX_CTL, 32'h0);
    wr(IDX_RX_CODE, 8'h00);
    rd(IDX_RX_CODE, 32'h3f);
    rd(10'h3ff, 32'h0);
    $display("register test done");
    c = 6'($urandom % 63);
    wr(IDX_TX_CODE, {2'b00, c});
    // The repeat is latched as the first pattern ends, so one more whole pattern leaves before the ones
    for (int k = 0; k < 48; k++) tq.push_back((k < 32) ? {31'h0, i_far.bit_oriented_message(c, k % 16)} : 32'h1);
    pulse_tx(16);
    wr(IDX_TX_CODE, 8'h3f);
    pulse_tx(32);
    $display("transmit test done");
    wr(IDX_RX_CTL, 8'h30);
    m = 6'($urandom % 63);
    i_far.send(m, 5);
    rd(IDX_RX_CODE, {26'h0, m});
    chk({31'h0, irq}, 32'h1);
    rd(IDX_RX_FLAG, 32'h1);
    wr(IDX_RX_FLAG, 8'h01);
    rd(IDX_RX_FLAG, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Stale window from the fast run must fail first, hence the long burst
    wr(IDX_RX_CTL, 8'h00);
    i_far.send(m ^ 6'h15, 18);
    rd(IDX_RX_CODE, {26'h0, m ^ 6'h15});
    rd(IDX_RX_FLAG, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("receive test done");
    pq.push_back({27'h0, c[4:0]});
    wr(IDX_REPORT_CTL, {2'b00, c[4:0], 1'b1});
    while (pq.size() > 0) @(posedge clk_sys);
    wr(IDX_REPORT_CTL, 8'h00);
    // Watch longer than one period: a stray report would show somewhere in it
    m = '0;
    repeat (60) @(posedge clk_sys) m[0] |= report_valid;
    chk({31'h0, m[0]}, 32'h0);
    $display("report test done");
    ch = 5'($urandom % 24);
    wr(IDX_TX2_MASK, 8'h80);
    wr(IDX_TX3_MASK, 8'h01);
    wr(IDX_TX2_ASSIGN, {3'b010, ch});
    wr(IDX_TX3_ASSIGN, {3'b011, ch ^ 5'h01});
    wr(IDX_TX_ENABLE, 8'h07);
    wr(IDX_RX_ENABLE, 8'h06);
    wr(IDX_RX2_ASSIGN, {3'b011, ch});
    wr(IDX_RX3_ASSIGN, {3'b001, ch});
    chk({26'h0, tx_link_active, rx_link_active}, 32'h3e);
    slot(1'b0, ch, 3'h0, 4'ha);
    slot(1'b0, ch, 3'h1, 4'h2);
    slot(1'b1, ch, 3'h0, 4'h3);
    slot(1'b0, ch ^ 5'h01, 3'h0, 4'h0);
    slot(1'b0, ch ^ 5'h01, 3'h7, 4'h4);
    wr(IDX_FORMAT, 8'h00);
    wr(IDX_TX2_ASSIGN, {3'b000, ch});
    slot(1'b0, ch, 3'h0, 4'h2);
    chk({29'h0, tx_link_active}, 32'h6);
    $display("timeslot test done");
    stop_test();
  end
endmodule
bind t1dlm_top t1dlm_checker i_chk (.*);
